// ===== dmae_consts.svh
`ifndef DMAE_CONSTS_SVH
`define DMAE_CONSTS_SVH

`define DMAE_AW 12
`define DMAE_DW 32

`define DMAE_OFF_CHAN_EN 12'h000
`define DMAE_OFF_BUS_FLAGS 12'h010
`define DMAE_OFF_BUS_MASK 12'h014
`define DMAE_OFF_ALIGN_EN 12'h018
`define DMAE_OFF_ALIGN_STAT 12'h020

`define DMAE_RST_WORD 32'h0000_0000
`define DMAE_ALL_ONES 32'hffff_ffff

`define DMAE_RESP_OKAY 2'h0
`define DMAE_RESP_SLVERR 2'h2

`endif

// ===== dmae_pkg.sv
package dmae_pkg;
`include "dmae_consts.svh"

	typedef enum logic [5:0]
	{
		DMAE_REG_NONE = 6'h01,
		DMAE_REG_CHAN_EN = 6'h02,
		DMAE_REG_BUS_FLAGS = 6'h04,
		DMAE_REG_BUS_MASK = 6'h08,
		DMAE_REG_ALIGN_EN = 6'h10,
		DMAE_REG_ALIGN_STAT = 6'h20
	} dmae_reg_t;

	typedef struct packed
	{
		logic awReady;
		logic wReady;
		logic awHeld;
		logic wHeld;
		logic [`DMAE_AW-1:0] awAddr;
		logic [`DMAE_DW-1:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic arReady;
		logic rValid;
		logic [`DMAE_DW-1:0] rData;
		logic [1:0] rResp;
		logic [`DMAE_DW-1:0] chanEn;
		logic [`DMAE_DW-1:0] busMask;
		logic [`DMAE_DW-1:0] alignEn;
		logic irq;
	} dmae_state_t;

endpackage

// ===== dmae_flag_if.sv
`timescale 1ns/1ps
interface dmae_flag_if #(parameter int Width = 32);
	logic [Width-1:0] set;
	logic [Width-1:0] clr;
	logic [Width-1:0] flags;

	modport bank
	(
		input set,
		input clr,
		output flags
	);

	modport user
	(
		output set,
		output clr,
		input flags
	);
endinterface

// ===== dmae_flag_bank.sv
`timescale 1ns/1ps
module dmae_flag_bank
	import dmae_pkg::*;
#(
	parameter int Width = 32
)
(
	input wire logic clk,
	input wire logic rst_n,
	dmae_flag_if.bank port
);
	typedef struct packed
	{
		logic [Width-1:0] flags;
	} dmae_bank_t;

	dmae_bank_t s;
	dmae_bank_t n;

	always_comb
	begin
		n = s;
		// an event in the clearing cycle survives: set is applied last
		n.flags = (s.flags & ~port.clr) | port.set;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end

	assign port.flags = s.flags;

	a_set_wins_clear:
	assert property (@(posedge clk) disable iff (!rst_n)
		(port.set & port.clr) != '0 |=> (port.flags & $past(port.set)) == $past(port.set))
	else $error("flag set in clearing cycle was lost");

	a_flag_no_spurious:
	assert property (@(posedge clk) disable iff (!rst_n)
		port.flags == '0 && port.set == '0 |=> port.flags == '0)
	else $error("flag rose without an event");
endmodule

// ===== dmae_err_irq.sv
`timescale 1ns/1ps
`include "dmae_consts.svh"
module dmae_err_irq
	import dmae_pkg::*;
#(
	parameter int NumChan = 32
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`DMAE_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [`DMAE_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`DMAE_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [`DMAE_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [`DMAE_DW-1:0] busErrEvent,
	input wire logic [`DMAE_DW-1:0] alignErrEvent,
	output logic [`DMAE_DW-1:0] chanEnable,
	output logic irq
);
	// channels NumChan and above are tied off and read as zero
	localparam logic [`DMAE_DW-1:0] ChanMask = (NumChan >= `DMAE_DW) ? `DMAE_ALL_ONES :
		`DMAE_DW'((64'h1 << NumChan) - 64'h1);

	dmae_state_t s;
	dmae_state_t n;

	logic awFire;
	logic wFire;
	logic arFire;
	logic doWrite;
	dmae_reg_t wrSel;
	dmae_reg_t rdSel;
	logic [`DMAE_DW-1:0] byteMask;
	logic [`DMAE_DW-1:0] busEvt;
	logic [`DMAE_DW-1:0] alignEvt;
	logic [`DMAE_DW-1:0] busClr;
	logic [`DMAE_DW-1:0] alignClr;

	dmae_flag_if #(.Width(`DMAE_DW)) busIf();
	dmae_flag_if #(.Width(`DMAE_DW)) alignIf();

	dmae_flag_bank #(.Width(`DMAE_DW)) u_bus_flags
	(
		.clk(clk),
		.rst_n(rst_n),
		.port(busIf.bank)
	);

	dmae_flag_bank #(.Width(`DMAE_DW)) u_align_flags
	(
		.clk(clk),
		.rst_n(rst_n),
		.port(alignIf.bank)
	);

	function automatic dmae_reg_t regDecode(input logic [`DMAE_AW-1:0] addr);
		logic [`DMAE_AW-1:0] word;
		word = {addr[`DMAE_AW-1:2], 2'h0};
		if (word == `DMAE_OFF_CHAN_EN)
			return DMAE_REG_CHAN_EN;
		else if (word == `DMAE_OFF_BUS_FLAGS)
			return DMAE_REG_BUS_FLAGS;
		else if (word == `DMAE_OFF_BUS_MASK)
			return DMAE_REG_BUS_MASK;
		else if (word == `DMAE_OFF_ALIGN_EN)
			return DMAE_REG_ALIGN_EN;
		else if (word == `DMAE_OFF_ALIGN_STAT)
			return DMAE_REG_ALIGN_STAT;
		else
			return DMAE_REG_NONE;
	endfunction

	function automatic logic [`DMAE_DW-1:0] strbMask(input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	function automatic logic [`DMAE_DW-1:0] wrMerge(
		input logic [`DMAE_DW-1:0] old,
		input logic [`DMAE_DW-1:0] data,
		input logic [`DMAE_DW-1:0] bm
	);
		return ((old & ~bm) | (data & bm)) & ChanMask;
	endfunction

	function automatic logic [`DMAE_DW-1:0] nextFlags(
		input logic [`DMAE_DW-1:0] cur,
		input logic [`DMAE_DW-1:0] clr,
		input logic [`DMAE_DW-1:0] set
	);
		return (cur & ~clr) | set;
	endfunction

	always_comb
	begin
		n = s;
		busEvt = busErrEvent & ChanMask;
		alignEvt = alignErrEvent & ChanMask;
		busClr = `DMAE_RST_WORD;
		alignClr = `DMAE_RST_WORD;
		awFire = s_axi_awvalid && s.awReady;
		wFire = s_axi_wvalid && s.wReady;
		arFire = s_axi_arvalid && s.arReady;

		if (s.bValid && s_axi_bready)
			n.bValid = 1'b0;
		if (awFire)
		begin
			n.awAddr = s_axi_awaddr;
			n.awHeld = 1'b1;
		end
		if (wFire)
		begin
			n.wData = s_axi_wdata;
			n.wStrb = s_axi_wstrb;
			n.wHeld = 1'b1;
		end

		// address and data may arrive in either order; commit once both are held
		doWrite = n.awHeld && n.wHeld && !s.bValid;
		wrSel = regDecode(n.awAddr);
		byteMask = strbMask(n.wStrb);
		if (doWrite)
		begin
			n.awHeld = 1'b0;
			n.wHeld = 1'b0;
			n.bValid = 1'b1;
			n.bResp = `DMAE_RESP_OKAY;
			if (wrSel == DMAE_REG_CHAN_EN)
				n.chanEn = wrMerge(s.chanEn, n.wData, byteMask);
			else if (wrSel == DMAE_REG_BUS_FLAGS)
				busClr = n.wData & byteMask & ChanMask;
			else if (wrSel == DMAE_REG_BUS_MASK)
				n.busMask = wrMerge(s.busMask, n.wData, byteMask);
			else if (wrSel == DMAE_REG_ALIGN_EN)
				n.alignEn = wrMerge(s.alignEn, n.wData, byteMask);
			else if (wrSel == DMAE_REG_ALIGN_STAT)
				alignClr = n.wData & byteMask & ChanMask;
			else
				n.bResp = `DMAE_RESP_SLVERR;
		end

		// the fault must stop the channel even if software enables it in the same cycle
		n.chanEn = n.chanEn & ~busEvt;

		n.awReady = !n.awHeld && !n.bValid;
		n.wReady = !n.wHeld && !n.bValid;

		if (s.rValid && s_axi_rready)
			n.rValid = 1'b0;
		rdSel = regDecode(s_axi_araddr);
		if (arFire)
		begin
			n.rValid = 1'b1;
			n.rResp = `DMAE_RESP_OKAY;
			if (rdSel == DMAE_REG_CHAN_EN)
				n.rData = s.chanEn;
			else if (rdSel == DMAE_REG_BUS_FLAGS)
				n.rData = busIf.flags;
			else if (rdSel == DMAE_REG_BUS_MASK)
				n.rData = s.busMask;
			else if (rdSel == DMAE_REG_ALIGN_EN)
				n.rData = s.alignEn;
			else if (rdSel == DMAE_REG_ALIGN_STAT)
				n.rData = alignIf.flags;
			else
			begin
				n.rData = `DMAE_RST_WORD;
				n.rResp = `DMAE_RESP_SLVERR;
			end
		end
		n.arReady = !n.rValid;

		// irq is registered from next-cycle flags and masks so it tracks them without lag
		n.irq = |((nextFlags(busIf.flags, busClr, busEvt) & n.busMask) |
			(nextFlags(alignIf.flags, alignClr, alignEvt) & n.alignEn));
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end

	assign busIf.set = busEvt;
	assign busIf.clr = busClr;
	assign alignIf.set = alignEvt;
	assign alignIf.clr = alignClr;

	assign s_axi_awready = s.awReady;
	assign s_axi_wready = s.wReady;
	assign s_axi_bvalid = s.bValid;
	assign s_axi_bresp = s.bResp;
	assign s_axi_arready = s.arReady;
	assign s_axi_rvalid = s.rValid;
	assign s_axi_rdata = s.rData;
	assign s_axi_rresp = s.rResp;
	assign chanEnable = s.chanEn;
	assign irq = s.irq;

	a_bus_flag_set:
	assert property (@(posedge clk) disable iff (!rst_n)
		busEvt != `DMAE_RST_WORD |=> (busIf.flags & $past(busEvt)) == $past(busEvt))
	else $error("bus error did not set its flag");

	a_chan_disable:
	assert property (@(posedge clk) disable iff (!rst_n)
		busEvt != `DMAE_RST_WORD |=> (chanEnable & $past(busEvt)) == `DMAE_RST_WORD)
	else $error("faulted channel still enabled");

	a_flag_w1c:
	assert property (@(posedge clk) disable iff (!rst_n)
		(busClr & ~busEvt) != `DMAE_RST_WORD |=> (busIf.flags & $past(busClr & ~busEvt)) == `DMAE_RST_WORD)
	else $error("write one did not clear bus error flag");

	a_flag_sticky:
	assert property (@(posedge clk) disable iff (!rst_n)
		!doWrite ##1 1'b1 |-> (busIf.flags & $past(busIf.flags)) == $past(busIf.flags))
	else $error("bus error flag dropped without a clear");

	a_mask_gate:
	assert property (@(posedge clk) disable iff (!rst_n)
		(alignIf.flags & s.alignEn) == `DMAE_RST_WORD && (busIf.flags & s.busMask) == `DMAE_RST_WORD |-> !irq)
	else $error("interrupt high with every source masked");

	a_enable_write:
	assert property (@(posedge clk) disable iff (!rst_n)
		doWrite && wrSel == DMAE_REG_ALIGN_EN && n.wStrb == 4'hf |=> s.alignEn == $past(n.wData & ChanMask))
	else $error("alignment enable write not stored");

	a_enable_read:
	assert property (@(posedge clk) disable iff (!rst_n)
		arFire && rdSel == DMAE_REG_ALIGN_EN |=> s_axi_rvalid && s_axi_rdata == $past(s.alignEn))
	else $error("alignment enable readback wrong");

	a_irq_level:
	assert property (@(posedge clk) disable iff (!rst_n)
		irq == |((alignIf.flags & s.alignEn) | (busIf.flags & s.busMask)))
	else $error("interrupt level disagrees with enabled status");

	a_write_resp:
	assert property (@(posedge clk) disable iff (!rst_n)
		doWrite |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
	else $error("write response missing");

	a_read_hold:
	assert property (@(posedge clk) disable iff (!rst_n)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
	else $error("read data not held under back-pressure");

	a_align_flag_set:
	assert property (@(posedge clk) disable iff (!rst_n)
		alignEvt != `DMAE_RST_WORD |=> (alignIf.flags & $past(alignEvt)) == $past(alignEvt))
	else $error("alignment error did not set its status");

	a_align_w1c:
	assert property (@(posedge clk) disable iff (!rst_n)
		(alignClr & ~alignEvt) != `DMAE_RST_WORD |=> (alignIf.flags & $past(alignClr & ~alignEvt)) == `DMAE_RST_WORD)
	else $error("write one did not clear alignment status");

	a_align_hold:
	assert property (@(posedge clk) disable iff (!rst_n)
		alignClr == `DMAE_RST_WORD |=> (alignIf.flags & $past(alignIf.flags)) == $past(alignIf.flags))
	else $error("alignment status dropped without a clear");

	a_bus_flag_hold:
	assert property (@(posedge clk) disable iff (!rst_n)
		(busEvt | busClr) == `DMAE_RST_WORD |=> $stable(busIf.flags))
	else $error("bus error flags moved without event or clear");

	a_chan_stays_off:
	assert property (@(posedge clk) disable iff (!rst_n)
		!(doWrite && wrSel == DMAE_REG_CHAN_EN) |=> (chanEnable & ~$past(chanEnable)) == `DMAE_RST_WORD)
	else $error("channel re-enabled without a software write");

	a_enable_hold:
	assert property (@(posedge clk) disable iff (!rst_n)
		!(doWrite && wrSel == DMAE_REG_ALIGN_EN) |=> $stable(s.alignEn))
	else $error("alignment enable changed without a write");

	a_irq_rise:
	assert property (@(posedge clk) disable iff (!rst_n)
		(alignEvt & n.alignEn) != `DMAE_RST_WORD |=> irq)
	else $error("enabled alignment error raised no interrupt");

	a_irq_unmasked:
	assert property (@(posedge clk) disable iff (!rst_n)
		(alignIf.flags & s.alignEn) != `DMAE_RST_WORD |-> irq)
	else $error("interrupt low with enabled status set");

	a_bresp_hold:
	assert property (@(posedge clk) disable iff (!rst_n)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
	else $error("write response not held under back-pressure");

	a_read_resp:
	assert property (@(posedge clk) disable iff (!rst_n)
		arFire |=> s_axi_rvalid && !s_axi_arready)
	else $error("read response missing");

	a_unmapped_write:
	assert property (@(posedge clk) disable iff (!rst_n)
		doWrite && wrSel == DMAE_REG_NONE |=> s_axi_bresp == `DMAE_RESP_SLVERR)
	else $error("unmapped write not refused");

	a_mapped_write:
	assert property (@(posedge clk) disable iff (!rst_n)
		doWrite && wrSel == DMAE_REG_ALIGN_EN |=> s_axi_bresp == `DMAE_RESP_OKAY)
	else $error("mapped write refused");
endmodule

// ===== dmae_fault_src.sv
`timescale 1ns/1ps
// far side of the channel transfers: each request bit is registered into an error answer one cycle later, held as long as the request
module dmae_fault_src
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [31:0] reqBus,
	input wire logic [31:0] reqAlign,
	output logic [31:0] busErrEvent,
	output logic [31:0] alignErrEvent
);
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			busErrEvent <= 32'h0;
			alignErrEvent <= 32'h0;
		end
		else
		begin
			busErrEvent <= reqBus;
			alignErrEvent <= reqAlign;
		end
	end
endmodule

// ===== dma_error_interrupt_flags_bench.sv
`timescale 1ns/1ps
`include "dmae_consts.svh"
module dma_error_interrupt_flags_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [11:0] awaddr = 12'h0;
	logic [11:0] araddr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] reqBus = 32'h0;
	logic [31:0] reqAlign = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic [31:0] busEv;
	logic [31:0] alignEv;
	logic [31:0] chanEn;
	logic [31:0] rdata;
	logic awready;
	logic wready;
	logic bvalid;
	logic arready;
	logic rvalid;
	logic irq;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [31:0] got;
	int fails = 0;
	int checked = 0;

	dmae_err_irq #(.NumChan(32)) uut
	(
		.clk(clk),
		.rst_n(rst_n),
		.s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid),
		.s_axi_awready(awready),
		.s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid),
		.s_axi_wready(wready),
		.s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid),
		.s_axi_bready(bready),
		.s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid),
		.s_axi_arready(arready),
		.s_axi_rdata(rdata),
		.s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid),
		.s_axi_rready(rready),
		.busErrEvent(busEv),
		.alignErrEvent(alignEv),
		.chanEnable(chanEn),
		.irq(irq)
	);

	dmae_fault_src u_src
	(
		.clk(clk),
		.rst_n(rst_n),
		.reqBus(reqBus),
		.reqAlign(reqAlign),
		.busErrEvent(busEv),
		.alignErrEvent(alignEv)
	);

	initial
	begin
		forever #2 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// both channels offered together; each is released at the edge that takes it
	task automatic axiWrite(input logic [11:0] addr, input logic [31:0] data);
		bit awDone;
		bit wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		awaddr <= addr;
		wdata <= data;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(awDone && wDone))
		begin
			@(posedge clk);
			if (!awDone && awready === 1'b1)
			begin
				awDone = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wDone && wready === 1'b1)
			begin
				wDone = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic axiRead(input logic [11:0] addr, output logic [31:0] data, output logic [1:0] resp);
		araddr <= addr;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		data = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic readCheck(input string what, input logic [11:0] addr, input logic [31:0] exp);
		logic [1:0] resp;
		axiRead(addr, got, resp);
		check(what, exp, got);
	endtask

	// one-cycle error answers from the far side, then time for flags and irq to settle
	task automatic fault(input logic [31:0] b, input logic [31:0] a);
		@(posedge clk);
		reqBus <= b;
		reqAlign <= a;
		@(posedge clk);
		reqBus <= 32'h0;
		reqAlign <= 32'h0;
		repeat (3) @(posedge clk);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		$display("ERROR watchdog expected finish seen timeout");
		report_and_stop();
	end

	initial
	begin
		logic [1:0] resp;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		readCheck("align enable reset", `DMAE_OFF_ALIGN_EN, 32'h0);
		readCheck("bus flags reset", `DMAE_OFF_BUS_FLAGS, 32'h0);
		check("irq reset", 32'h0, {31'h0, irq});
		$display("test reset done");

		axiWrite(`DMAE_OFF_ALIGN_EN, 32'hffff_0001);
		readCheck("align enable upper", `DMAE_OFF_ALIGN_EN, 32'hffff_0001);
		axiWrite(`DMAE_OFF_ALIGN_EN, 32'h0);
		readCheck("align enable cleared", `DMAE_OFF_ALIGN_EN, 32'h0);
		$display("test enable register done");

		axiWrite(`DMAE_OFF_CHAN_EN, 32'hffff_ffff);
		fault(32'h8001_0001, 32'h0);
		readCheck("bus flags set", `DMAE_OFF_BUS_FLAGS, 32'h8001_0001);
		check("channel disabled", 32'h7ffe_fffe, chanEn);
		readCheck("channel enable read", `DMAE_OFF_CHAN_EN, 32'h7ffe_fffe);
		axiWrite(`DMAE_OFF_BUS_FLAGS, 32'h0001_0000);
		readCheck("bus flag w1c", `DMAE_OFF_BUS_FLAGS, 32'h8000_0001);
		axiWrite(`DMAE_OFF_BUS_FLAGS, 32'hffff_ffff);
		readCheck("bus flags clear", `DMAE_OFF_BUS_FLAGS, 32'h0);
		$display("test bus error done");

		fault(32'h0, 32'h0000_0004);
		check("irq masked", 32'h0, {31'h0, irq});
		readCheck("align status", `DMAE_OFF_ALIGN_STAT, 32'h0000_0004);
		axiWrite(`DMAE_OFF_ALIGN_EN, 32'h0000_0004);
		check("irq unmasked", 32'h1, {31'h0, irq});
		axiWrite(`DMAE_OFF_ALIGN_STAT, 32'h0000_0004);
		check("irq cleared", 32'h0, {31'h0, irq});
		axiRead(12'h0fc, got, resp);
		check("unmapped read resp", {30'h0, `DMAE_RESP_SLVERR}, {30'h0, resp});
		$display("test alignment interrupt done");

		@(posedge clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		readCheck("align enable after reset", `DMAE_OFF_ALIGN_EN, 32'h0);
		readCheck("align status after reset", `DMAE_OFF_ALIGN_STAT, 32'h0);
		check("chan enable after reset", 32'h0, chanEn);
		$display("test second reset done");
		report_and_stop();
	end
endmodule

// ===== dma_error_interrupt_flags_bench_top.sv
`timescale 1ns/1ps
